/* File: logic/qic_pkg.sv */
package qic_pkg;
  // Register map (byte addresses)
  localparam logic [11:0] QIC_IO_CONTROL_OFS = 12'h000;
  localparam logic [11:0] QIC_COND_STATUS_OFS = 12'h004;
  localparam logic [15:0] QIC_IO_CONTROL_RST = 16'h0000;
  // Field positions in encoder_io_control
  localparam int QIC_CAPEN_BIT  = 15;
  localparam int QIC_FLTEN_BIT  = 14;
  localparam int QIC_FDIV_LSB   = 11;
  localparam int QIC_OFUNC_LSB  = 9;
  localparam int QIC_SWAP_BIT   = 8;
  localparam int QIC_HOMEINV_BIT = 7;
  localparam int QIC_IDXINV_BIT  = 6;
  localparam int QIC_BINV_BIT    = 5;
  localparam int QIC_AINV_BIT    = 4;
  localparam int QIC_WR_MASK_W  = 16;
  localparam logic [15:0] QIC_WR_MASK = 16'hFFF0;
  // Filter: consecutive equal samples needed to accept a new level
  localparam int QIC_FILT_SAMPLES = 3;
  localparam int QIC_FDIV_MAX_LOG = 7;

  typedef enum logic [1:0] {
    QIC_OUT_OFF,
    QIC_OUT_GE,
    QIC_OUT_LE,
    QIC_OUT_WIN
  } qic_ofunc_e;

  typedef struct packed {
    logic home;
    logic index;
    logic phase_b;
    logic phase_a;
  } qic_pins_s;

  typedef struct packed {
    logic       position_capture_enable;
    logic       input_filter_enable;
    logic [2:0] filter_clock_divide;
    qic_ofunc_e compare_output_function;
    logic       phase_swap;
    logic       home_input_invert;
    logic       index_input_invert;
    logic       phase_b_invert;
    logic       phase_a_invert;
  } qic_ctrl_s;
endpackage : qic_pkg

/* File: logic/qic_filter.sv */
module qic_filter
  import qic_pkg::*;
#(
  parameter int WIDTH   = 4,
  parameter int SAMPLES = QIC_FILT_SAMPLES
) (
  input  wire logic             pclk,    // Clock
  input  wire logic             presetn, // Async reset, low
  input  wire logic             ce,      // Clock enable
  input  wire logic             tick,    // Sample strobe
  input  wire logic [WIDTH-1:0] din,     // Raw inputs
  output logic      [WIDTH-1:0] dout     // Filtered levels
);
  if (WIDTH < 1 || SAMPLES < 2 || SAMPLES > 15) begin : g_bad_param
    $error("qic_filter: WIDTH or SAMPLES out of range");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_ch
    logic [3:0] cnt_r, cnt_nxt;
    logic       lvl_r, lvl_nxt;
    always_comb begin
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      if (tick) begin
        if (din[i] == lvl_r) begin
          cnt_nxt = 4'h0;
        end else if (cnt_r == 4'(SAMPLES - 1)) begin
          // Level must hold for SAMPLES strobes before it is accepted
          lvl_nxt = din[i];
          cnt_nxt = 4'h0;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= 4'h0;
        lvl_r <= 1'b0;
      end else if (ce) begin
        cnt_r <= cnt_nxt;
        lvl_r <= lvl_nxt;
      end
    end
    assign dout[i] = lvl_r;
  end
endmodule : qic_filter

/* File: logic/qic_top.sv */
// Contract
// (R1) Filter enable routes inputs through filter
// (R2) Divide codes 7..4 give 128..16
// (R3) Divide codes 3..1 give 8, 4, 2
// (R4) Phase swap exchanges A and B
// (R5) Per-input inversion; status shows post-polarity levels
module qic_top
  import qic_pkg::*;
#(
  parameter int POS_W = 16
) (
  input  wire logic             pclk,                // 200 MHz clock
  input  wire logic             presetn,             // Async reset, low
  input  wire logic             ce,                  // Freezes state when low
  input  wire logic             psel,                // APB select
  input  wire logic             penable,             // APB enable
  input  wire logic             pwrite,              // APB direction
  input  wire logic [11:0]      paddr,               // APB byte address
  input  wire logic [31:0]      pwdata,              // APB write data
  input  wire logic [3:0]       pstrb,               // APB byte strobes
  output logic      [31:0]      prdata,              // APB read data
  output logic                  pready,              // APB ready
  output logic                  pslverr,             // APB error
  input  wire qic_pins_s        pins,                // Encoder pins
  input  wire logic [POS_W-1:0] position_counter,    // Counter value
  input  wire logic [POS_W-1:0] greater_equal_compare_value, // Upper compare
  input  wire logic [POS_W-1:0] less_equal_compare_value,    // Lower compare
  output qic_pins_s             decoder_pins,        // Conditioned pins
  output logic                  position_capture_enable, // Capture enable
  output logic                  compare_output_pin   // Compare output
);
  if (POS_W < 1 || POS_W > 32) begin : g_bad_pos_w
    $error("qic_top: POS_W out of range");
  end

  qic_ctrl_s  ctrl_r, ctrl_nxt;
  logic [31:0] prdata_nxt;
  logic       pready_nxt, pslverr_nxt;
  logic [6:0] div_r, div_nxt;
  logic       tick_r, tick_nxt;
  qic_pins_s  pol_in, filt_out, dec_nxt;
  logic       cmp_nxt;
  logic       setup;
  logic       hit_ctl, hit_sts;
  logic [15:0] wr_val;

  assign setup   = psel && !penable;
  assign hit_ctl = paddr == QIC_IO_CONTROL_OFS;
  assign hit_sts = paddr == QIC_COND_STATUS_OFS;

  // APB slave: answer with pready in the access cycle, one wait-free transfer
  always_comb begin
    ctrl_nxt    = ctrl_r;
    prdata_nxt  = prdata;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    // Control struct holds register bits 15:4 only
    wr_val      = {ctrl_r, 4'h0};
    if (pstrb[0]) wr_val[7:0] = pwdata[7:0];
    if (pstrb[1]) wr_val[15:8] = pwdata[15:8];
    if (setup) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !(hit_ctl || hit_sts);
      prdata_nxt  = 32'h0000_0000;
      if (pwrite) begin
        // Low nibble is read-only pin status
        if (hit_ctl) ctrl_nxt = qic_ctrl_s'(wr_val[15:4]);
      end else if (hit_ctl) begin
        prdata_nxt = {16'h0000, ctrl_r, 4'(dec_nxt)}; // [R5]
      end else if (hit_sts) begin
        prdata_nxt = {28'h0000000, 4'(decoder_pins)};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= qic_ctrl_s'(QIC_IO_CONTROL_RST[15:4]);
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrl_r  <= ctrl_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Filter sample strobe; code 000 also divides by 1:1 (every clock)
  always_comb begin
    div_nxt  = div_r + 7'h01;
    tick_nxt = 1'b1;
    unique case (ctrl_r.filter_clock_divide)
      3'h7: tick_nxt = div_r[6:0] == 7'h7F; // [R2]
      3'h6: tick_nxt = div_r[5:0] == 6'h3F; // [R2]
      3'h5: tick_nxt = div_r[4:0] == 5'h1F; // [R2]
      3'h4: tick_nxt = div_r[3:0] == 4'hF;  // [R2]
      3'h3: tick_nxt = div_r[2:0] == 3'h7;  // [R3]
      3'h2: tick_nxt = div_r[1:0] == 2'h3;  // [R3]
      3'h1: tick_nxt = div_r[0];            // [R3]
      3'h0: tick_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (ce) begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Polarity first, so the filter sees the logical level
  always_comb begin
    pol_in.home    = pins.home    ^ ctrl_r.home_input_invert;  // [R5]
    pol_in.index   = pins.index   ^ ctrl_r.index_input_invert; // [R5]
    pol_in.phase_b = pins.phase_b ^ ctrl_r.phase_b_invert;     // [R5]
    pol_in.phase_a = pins.phase_a ^ ctrl_r.phase_a_invert;     // [R5]
  end

  qic_filter #(
    .WIDTH   (4),
    .SAMPLES (QIC_FILT_SAMPLES)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (tick_r),
    .din     (4'(pol_in)),
    .dout    (filt_out)
  );

  always_comb begin
    dec_nxt = ctrl_r.input_filter_enable ? filt_out : pol_in; // [R1]
    if (ctrl_r.phase_swap) begin
      dec_nxt.phase_a = ctrl_r.input_filter_enable ? filt_out.phase_b : pol_in.phase_b; // [R4]
      dec_nxt.phase_b = ctrl_r.input_filter_enable ? filt_out.phase_a : pol_in.phase_a; // [R4]
    end
  end

  always_comb begin
    unique case (ctrl_r.compare_output_function)
      QIC_OUT_GE:  cmp_nxt = position_counter >= greater_equal_compare_value;
      QIC_OUT_LE:  cmp_nxt = position_counter <= less_equal_compare_value;
      QIC_OUT_WIN: cmp_nxt = position_counter >= less_equal_compare_value &&
                             position_counter <= greater_equal_compare_value;
      QIC_OUT_OFF: cmp_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decoder_pins            <= qic_pins_s'(4'h0);
      position_capture_enable <= 1'b0;
      compare_output_pin      <= 1'b0;
    end else if (ce) begin
      decoder_pins            <= dec_nxt;
      position_capture_enable <= ctrl_r.position_capture_enable;
      compare_output_pin      <= cmp_nxt;
    end
  end
endmodule : qic_top

/* File: sim/qic_properties.sv */
module qic_properties
  import qic_pkg::*;
(
  input wire logic        pclk,        // Clock
  input wire logic        presetn,     // Reset
  input wire logic        ce,          // Run
  input wire logic        psel,        // Select
  input wire logic        penable,     // Access
  input wire logic        pwrite,      // Write
  input wire logic [11:0] paddr,       // Address
  input wire logic [31:0] pwdata,      // Wdata
  input wire logic [31:0] prdata,      // Rdata
  input wire logic        pready,      // Ready
  input wire logic        pslverr,     // Error
  input wire qic_pins_s   pins,        // Raw
  input wire qic_pins_s   decoder_pins // Out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctl_r, ctl_nxt;
  logic [9:0]  stb_r, stb_nxt, lim;
  qic_pins_s   pin_r;
  wire         setup = ce && psel && !penable;
  function automatic qic_pins_s cond(qic_pins_s p, logic [15:0] c);
    logic [3:0] v;
    v = p ^ c[7:4];
    return c[8] ? {v[3:2], v[0], v[1]} : v;
  endfunction : cond
  // Loose bound: three ticks, phase slack, two flops
  assign lim = 10'(4 << ctl_r[13:11]) + 10'h004;
  always_comb begin
    ctl_nxt = ctl_r;
    if (setup && pwrite && paddr == QIC_IO_CONTROL_OFS) begin
      ctl_nxt = pwdata[15:0] & QIC_WR_MASK;
    end
    stb_nxt = (pins != pin_r || ctl_nxt != ctl_r) ? 10'h000 : stb_r + 10'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= QIC_IO_CONTROL_RST;
      stb_r <= 10'h000;
      pin_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
      stb_r <= stb_nxt;
      pin_r <= pins;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_bypass_path: assert property (ce && !ctl_r[14] && $past(presetn)
    |=> decoder_pins == cond($past(pins), $past(ctl_r))) else $error("bypass pins wrong");
  chk_filter_settle: assert property (ctl_r[14] && stb_r == lim
    |-> decoder_pins == cond(pins, ctl_r)) else $error("filtered pins late");
  chk_ctrl_readback: assert property (setup && !pwrite && paddr == QIC_IO_CONTROL_OFS
    |=> prdata[31:4] == {16'h0000, ctl_r[15:4]}) else $error("control readback wrong");
  chk_ready_pulse: assert property (setup |=> pready ##1 !pready) else $error("ready not one cycle");
  chk_unmapped_error: assert property (setup && paddr != QIC_IO_CONTROL_OFS && paddr != QIC_COND_STATUS_OFS
    |=> pready && pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  cov_filter: cover property (ctl_r[14] && stb_r == lim);
  cov_swap: cover property (ctl_r[8] && $changed(decoder_pins));
  cov_err: cover property (pready && pslverr);
endmodule : qic_properties
bind qic_top qic_properties i_qic_properties (.*);

/* File: sim/qic_encoder_model.sv */
module qic_encoder_model
  import qic_pkg::*;
(
  input wire logic  pclk, // Clock
  input wire logic  step, // Advance one edge
  input wire logic  home, // Home switch
  output qic_pins_s pins  // Pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  // Gray order so each step moves one phase line
  always @(posedge pclk) if (step) ph <= ph + 2'h1;
  assign pins = {home, ph == 2'h0, ph[1], ^ph};
endmodule : qic_encoder_model

/* File: sim/qic_tb_top.sv */
module qic_tb_top
  import qic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, step = 0, home = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] c;
  logic        pready, pslverr, er;
  qic_pins_s   pins, dec, old;
  logic [15:0] pos = '0, gev = 16'h0008, lev = 16'h0004;
  logic [8:0]  exp_tab = 9'h062; // {window, le, ge} for positions 2, 6, 10
  logic        cap, cmp;
  int          n_errors = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  qic_encoder_model i_qic_encoder_model (.pclk(pclk), .step(step), .home(home), .pins(pins));
  qic_top i_qic_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .position_counter(pos), .greater_equal_compare_value(gev),
    .less_equal_compare_value(lev), .decoder_pins(dec), .position_capture_enable(cap), .compare_output_pin(cmp));
  function automatic qic_pins_s cond(qic_pins_s p, logic [15:0] k);
    logic [3:0] v;
    v = p ^ k[7:4];
    return k[8] ? {v[3:2], v[0], v[1]} : v;
  endfunction : cond
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, QIC_IO_CONTROL_OFS, '0);
    chk({rd[31:4], 3'h0, er}, {16'h0000, QIC_IO_CONTROL_RST[15:4], 4'h0});
    xfer(0, 12'h008, '0);
    chk({rd[30:0], er}, 32'h0000_0001);
    for (int k = 0; k < 32; k++) begin
      c = 16'(k << 4) | 16'h000F;
      xfer(1, QIC_IO_CONTROL_OFS, {16'h0000, c});
      home <= k[0];
      step <= 1'b1;
      @(posedge pclk);
      step <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(dec), 32'(cond(pins, c)));
      xfer(0, QIC_COND_STATUS_OFS, '0);
      chk(rd, 32'(cond(pins, c)));
      xfer(0, QIC_IO_CONTROL_OFS, '0);
      chk(32'(rd[31:4]), 32'(c[15:4]));
    end
    for (int q = 0; q < 8; q++) begin
      c = 16'h4000 | 16'(q << 11);
      xfer(1, QIC_IO_CONTROL_OFS, {16'h0000, c});
      repeat (520) @(posedge pclk);
      old = cond(pins, c);
      step <= 1'b1;
      @(posedge pclk);
      step <= 1'b0;
      repeat ((2 << q) - 1) @(posedge pclk);
      chk(32'(dec), 32'(old));
      repeat ((2 << q) + 6) @(posedge pclk);
      chk(32'(dec), 32'(cond(pins, c)));
    end
    for (int f = 0; f < 4; f++) begin
      for (int p = 0; p < 3; p++) begin
        pos <= 16'(2 + 4 * p);
        c = (16'(f[0]) << 15) | 16'(f << 9);
        xfer(1, QIC_IO_CONTROL_OFS, {16'h0000, c});
        @(posedge pclk);
        chk(32'(cmp), 32'((f == 0) ? 1'b0 : exp_tab[3 * p + f - 1]));
        chk(32'(cap), 32'(f[0]));
      end
    end
    stop_test();
  end
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end
endmodule : qic_tb_top
